// File: rtl/sac_adc_ctrl.sv
/*
   successive-approximation converter control with an apb register slave.
   assumes an external dac, comparator and sample-and-hold with an 8-way mux;
   the comparator output is asynchronous to clk.
*/
// Our own choice: register access over APB.
// Behaviour
// R1: convert the selected one of eight channels to 8 bits by successive approximation.
// R2: mode register written whole; done and start bits also settable and clearable alone.
// R3: reset loads mode register with 04h, only done flag set.
// R4: conversion begins at most sixteen clocks after the start bit is set.
// R5: result register is 8 bits, read-only, whole reads only.
// R6: reset leaves result register undefined.
// R7: starting a conversion invalidates the previous result.
// R8: mode bits 6..4 select the analog channel.
// R9: hardware clears the start bit itself once conversion starts.
// R10: at the end, result is loaded and the done flag set.
// R11: done flag cleared within sixteen clocks of the start bit being set.
// R12: one conversion takes 168 main clock periods.
// R13: software waits per clock divider setting before polling the done flag.
// R14: converter runs on main clock only; stops in stop, or halt on subclock.
// R15: software avoids reading the shared port while channels 4..7 convert.
// R16: writing 08h selects channel 0 and starts conversion.
// R17: channel field n routes input n; bias select sits in bit 7.
// R18: with the main oscillator stopped no conversion runs.
// R19: bits resolved from msb to lsb, one trial per step, eight steps.
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl
   import sac_pkg::*;
(
   input  wire  logic              clk,
   input  wire  logic              rst,
   input  wire  logic              psel,
   input  wire  logic              penable,
   input  wire  logic              pwrite,
   input  wire  logic [ADDR_W-1:0] paddr,
   input  wire  logic [31:0]       pwdata,
   output var   logic [31:0]       prdata,
   output var   logic              pready,
   output var   logic              pslverr,
   input  wire  logic              stop_mode,
   input  wire  logic              halt_mode,
   input  wire  logic              cmp_in,
   output var   logic [7:0]        dac_code,
   output var   logic [2:0]        channel_sel,
   output var   logic              sample_hold,
   output var   logic              bias_sel
);
   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   wire logic [11:0] idx       = paddr[ADDR_W-1:2];
   wire logic        hit_mode  = (idx == IDX_MODE);
   wire logic        hit_res   = (idx == IDX_RESULT);
   wire logic        hit_mset  = (idx == IDX_MSET);
   wire logic        hit_mclr  = (idx == IDX_MCLR);
   wire logic        hit_clk   = (idx == IDX_CLKCTL);
   wire logic        mapped    = hit_mode | hit_res | hit_mset | hit_mclr | hit_clk;
   // result is read-only: a write there is an error
   wire logic        bad       = ~mapped | (pwrite & hit_res); // R5
   wire logic        first_acc = psel & penable & ~pready;
   wire logic        commit    = psel & penable & pready & pwrite & ~bad;
   wire logic        wr_mode   = commit & hit_mode;
   wire logic        wr_mset   = commit & hit_mset;
   wire logic        wr_mclr   = commit & hit_mclr;
   wire logic        wr_clk    = commit & hit_clk;

   sac_mode_s   mode_r;
   sac_mode_s   mode_nxt;
   sac_clkctl_s clk_r;
   logic [7:0]  result_r;
   logic [7:0]  result_nxt;
   sac_state_e  st_r;
   sac_state_e  st_nxt;
   logic [3:0]  pre_r;
   logic [4:0]  cnt_r;
   logic [4:0]  cnt_nxt;
   logic [2:0]  step_r;
   logic [2:0]  step_nxt;
   logic [7:0]  dac_nxt;
   logic        cmp_s1;
   logic        cmp_s2;
   logic        cmp_s3;
   logic        cmp_q;

   // a write that raises the start bit, whole or through the set register
   wire logic soc_req  = (wr_mode & pwdata[BIT_START]) | (wr_mset & pwdata[BIT_START]); // R16
   // conversion runs only while the main clock feeds it
   wire logic stalled  = clk_r.main_osc_stop_bit | stop_mode
                         | (halt_mode & clk_r.cpu_clock_source_bit); // R14 R18
   wire logic go       = ~stalled & ~soc_req & (st_r == ST_ALIGN) & (pre_r == PRE_LAST); // R4
   wire logic step_end = ~stalled & (st_r == ST_STEP) & (cnt_r == STEP_LAST); // R12
   wire logic done     = step_end & (step_r == STEP_FINAL);
   wire logic [2:0] bit_k = 3'(STEP_FINAL - step_r);

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   wire logic [7:0] rd_byte = hit_mode ? mode_r :
                              hit_res  ? result_r :
                              hit_clk  ? clk_r : DAC_ZERO;

   // ---------------------------------------------------------------
   // apb answer: pready one cycle into the access phase
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= first_acc;
         pslverr <= first_acc & bad;
         prdata  <= (first_acc & ~pwrite) ? {24'h000000, rd_byte} : '0;
      end
   end

   // ---------------------------------------------------------------
   // comparator synchroniser: change counts once stages 2 and 3 agree
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
         cmp_s3 <= 1'b0;
         cmp_q  <= 1'b0;
      end
      else
      begin
         cmp_s1 <= cmp_in;
         cmp_s2 <= cmp_s1;
         cmp_s3 <= cmp_s2;
         if (cmp_s2 == cmp_s3)
            cmp_q <= cmp_s3;
      end
   end

   // ---------------------------------------------------------------
   // mode register next value
   // ---------------------------------------------------------------
   always_comb
   begin
      mode_nxt = mode_r;
      if (wr_mode)
         mode_nxt = sac_mode_s'(pwdata[7:0]); // R2 R8 R17
      if (wr_mset)
      begin
         mode_nxt.start = mode_nxt.start | pwdata[BIT_START]; // R2
         mode_nxt.done  = mode_nxt.done  | pwdata[BIT_DONE];
      end
      if (wr_mclr)
      begin
         mode_nxt.start = mode_nxt.start & ~pwdata[BIT_START]; // R2
         mode_nxt.done  = mode_nxt.done  & ~pwdata[BIT_DONE];
      end
      if (go & ~soc_req)
         mode_nxt.start = 1'b0; // R9
      if (go)
         mode_nxt.done = 1'b0; // R11
      // hardware set wins over a software clear in the same cycle
      if (done)
         mode_nxt.done = 1'b1; // R10
      mode_nxt.unused = 2'b00;
   end

   // ---------------------------------------------------------------
   // sequencer next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      step_nxt   = step_r;
      dac_nxt    = dac_code;
      result_nxt = result_r;
      if (soc_req)
         st_nxt = ST_ALIGN;
      else if (!stalled)
      begin
         case (st_r)
            ST_IDLE:
            begin
               if (mode_r.start)
                  st_nxt = ST_ALIGN;
            end
            ST_ALIGN:
            begin
               if (go)
               begin
                  st_nxt     = ST_SAMPLE;
                  cnt_nxt    = '0;
                  result_nxt = RES_DEAD; // R7
               end
            end
            ST_SAMPLE:
            begin
               cnt_nxt = 5'(cnt_r + 5'd1);
               if (cnt_r == SAMPLE_LAST)
               begin
                  st_nxt   = ST_STEP;
                  cnt_nxt  = '0;
                  step_nxt = '0;
                  dac_nxt  = DAC_MSB; // R19
               end
            end
            ST_STEP:
            begin
               cnt_nxt = 5'(cnt_r + 5'd1);
               if (step_end)
               begin
                  cnt_nxt        = '0;
                  dac_nxt[bit_k] = cmp_q; // R1 R19
                  if (done)
                  begin
                     st_nxt     = ST_IDLE;
                     result_nxt = dac_nxt; // R10
                  end
                  else
                  begin
                     step_nxt           = 3'(step_r + 3'd1);
                     dac_nxt[bit_k - 1] = 1'b1;
                  end
               end
            end
            default:
               st_nxt = ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_r      <= sac_mode_s'(MODE_RST); // R3
         clk_r       <= sac_clkctl_s'(CLK_RST);
         st_r        <= ST_IDLE;
         pre_r       <= '0;
         cnt_r       <= '0;
         step_r      <= '0;
         dac_code    <= DAC_ZERO;
         channel_sel <= '0;
         sample_hold <= 1'b0;
         bias_sel    <= 1'b0;
      end
      else
      begin
         mode_r      <= mode_nxt;
         if (wr_clk)
            clk_r <= sac_clkctl_s'(pwdata[7:0]);
         st_r        <= st_nxt;
         pre_r       <= 4'(pre_r + 4'd1);
         cnt_r       <= cnt_nxt;
         step_r      <= step_nxt;
         dac_code    <= dac_nxt;
         channel_sel <= mode_nxt.channel_select; // R8 R17
         sample_hold <= (st_nxt == ST_SAMPLE);
         bias_sel    <= mode_nxt.bias_sel;
      end
   end

   // result is left without reset on purpose
   always_ff @(posedge clk)
   begin
      result_r <= result_nxt; // R6
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [7:0] run_cnt_r;
   logic [4:0] wait_cnt_r;
   always_ff @(posedge clk)
   begin
      if (rst || go)
         run_cnt_r <= '0;
      else if (!stalled && st_r != ST_IDLE && st_r != ST_ALIGN)
         run_cnt_r <= 8'(run_cnt_r + 8'd1);
      if (rst || soc_req || st_r != ST_ALIGN)
         wait_cnt_r <= '0;
      else if (!stalled)
         wait_cnt_r <= 5'(wait_cnt_r + 5'd1);
   end

   mode_reset_a: assert property (@(posedge clk) $past(rst) |-> mode_r == MODE_RST) // R3
      else $error("mode register not 04h after reset");
   start_wait_a: assert property (@(posedge clk) disable iff (rst) wait_cnt_r < 5'(START_MAX_CYC)) // R4
      else $error("conversion did not begin within sixteen clocks");
   start_clear_a: assert property (@(posedge clk) disable iff (rst)
      (go && !soc_req) |=> !mode_r.start) // R9
      else $error("start bit not cleared by hardware");
   done_low_a: assert property (@(posedge clk) disable iff (rst)
      (st_r == ST_STEP && !done && !wr_mode && !wr_mset) |=> !mode_r.done) // R11
      else $error("done flag high during conversion");
   conv_len_a: assert property (@(posedge clk) disable iff (rst)
      done |-> run_cnt_r == 8'(CONV_CYC - 1)) // R12
      else $error("conversion length is not 168 clocks");
   result_load_a: assert property (@(posedge clk) disable iff (rst)
      done |=> mode_r.done && result_r == dac_code) // R10
      else $error("result or done flag wrong at completion");
   osc_stop_a: assert property (@(posedge clk) disable iff (rst)
      (clk_r.main_osc_stop_bit && !soc_req) |=> st_r == $past(st_r)) // R18 R14
      else $error("sequencer moved with main oscillator stopped");
   msb_first_a: assert property (@(posedge clk) disable iff (rst)
      (st_r == ST_SAMPLE && st_nxt == ST_STEP) |=> dac_code == DAC_MSB ##20 dac_code[6]) // R19
      else $error("first trial is not msb");
   result_ro_a: assert property (@(posedge clk) disable iff (rst)
      (first_acc && pwrite && hit_res) |=> pslverr && pready) // R5
      else $error("write to result register not refused");
   invalid_a: assert property (@(posedge clk) disable iff (rst)
      go |=> result_r == RES_DEAD) // R7
      else $error("old result survived a new start");
endmodule
`default_nettype wire

// File: rtl/sac_pkg.sv
/*
   constants, register map and field layouts of the converter control block.
   assumes a 100 MHz main clock and 32-bit apb data.
*/
`default_nettype none
package sac_pkg;
   // ---------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ---------------------------------------------------------------
   localparam logic [11:0] IDX_MODE   = 12'hfd8;
   localparam logic [11:0] IDX_RESULT = 12'hfda;
   localparam logic [11:0] IDX_MSET   = 12'hfdb;
   localparam logic [11:0] IDX_MCLR   = 12'hfdc;
   localparam logic [11:0] IDX_CLKCTL = 12'hfdd;
   localparam int          ADDR_W     = 14;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int        BIT_DONE   = 2;
   localparam int        BIT_START  = 3;
   localparam logic [7:0] MODE_RST  = 8'h04;
   localparam logic [7:0] CLK_RST   = 8'h00;
   localparam logic [7:0] RES_DEAD  = 8'h00;
   localparam logic [7:0] DAC_MSB   = 8'h80;
   localparam logic [7:0] DAC_ZERO  = 8'h00;

   // ---------------------------------------------------------------
   // timing, in main clock periods
   // ---------------------------------------------------------------
   localparam int         START_MAX_CYC = 16;
   localparam int         CONV_CYC      = 168;
   localparam int         SAMPLE_CYC    = 8;
   localparam int         STEPS         = 8;
   localparam int         STEP_CYC      = (CONV_CYC - SAMPLE_CYC) / STEPS;
   localparam logic [3:0] PRE_LAST      = 4'(START_MAX_CYC - 1);
   localparam logic [4:0] SAMPLE_LAST   = 5'(SAMPLE_CYC - 1);
   localparam logic [4:0] STEP_LAST     = 5'(STEP_CYC - 1);
   localparam logic [2:0] STEP_FINAL    = 3'(STEPS - 1);

   typedef struct packed {
      logic       bias_sel;
      logic [2:0] channel_select;
      logic       start;
      logic       done;
      logic [1:0] unused;
   } sac_mode_s;

   typedef struct packed {
      logic [1:0] unused_hi;
      logic [1:0] cpu_clock_divider;
      logic       main_osc_stop_bit;
      logic [1:0] unused_mid;
      logic       cpu_clock_source_bit;
   } sac_clkctl_s;

   typedef enum {ST_IDLE, ST_ALIGN, ST_SAMPLE, ST_STEP} sac_state_e;
endpackage
`default_nettype wire

// File: test/sac_adc_ctrl_bench.sv
/*
   self-checking bench for the converter control block over apb.
   assumes the analog model on the far side and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl_bench
   import sac_pkg::*;
;
   localparam logic [13:0] A_MODE = {IDX_MODE, 2'b00};
   localparam logic [13:0] A_RES  = {IDX_RESULT, 2'b00};
   localparam logic [13:0] A_SET  = {IDX_MSET, 2'b00};
   localparam logic [13:0] A_CLR  = {IDX_MCLR, 2'b00};
   localparam logic [13:0] A_CLK  = {IDX_CLKCTL, 2'b00};
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic stop_mode, halt_mode, cmp_in, sample_hold, bias_sel;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  dac_code, q, d;
   logic [2:0]  channel_sel;
   logic [63:0] levels;
   logic [33:0] notes[$];
   logic [33:0] note;
   int          n_errors, cmp_count, n, k;

   sac_adc_ctrl u_sac_adc_ctrl (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stop_mode(stop_mode), .halt_mode(halt_mode), .cmp_in(cmp_in), .dac_code(dac_code),
      .channel_sel(channel_sel), .sample_hold(sample_hold), .bias_sel(bias_sel));
   sac_analog_model u_sac_analog_model (.clk(clk), .levels(levels), .channel_sel(channel_sel),
      .sample_hold(sample_hold), .dac_code(dac_code), .cmp_in(cmp_in));

   function automatic logic [7:0] lev(input int ch);
      return levels[ch*8 +: 8];
   endfunction

   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // -------------------------------------------------------------
   // apb master: note the expectation, then run setup and access
   // -------------------------------------------------------------
   task automatic xfer(input logic [13:0] a, input logic w, input logic [7:0] dv, input logic [33:0] nt);
      notes.push_back(nt);
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, dv};
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      q = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] a, input logic [7:0] dv);
      xfer(a, 1'b1, dv, {2'b10, 32'h0});
   endtask

   task automatic rd(input logic [13:0] a, input logic [7:0] e);
      xfer(a, 1'b0, 8'h00, {2'b10, 24'h0, e});
   endtask

   task automatic wait_done();
      int i;
      for (i = 0; i < 120; i++)
      begin
         xfer(A_MODE, 1'b0, 8'h00, 34'h0);
         if (q[BIT_DONE] === 1'b1)
            break;
      end
      check("done seen", {32'h0, q[BIT_DONE]}, 33'h1);
   endtask

   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // -------------------------------------------------------------
   // monitor: every answered transfer consumes the oldest note
   // -------------------------------------------------------------
   always @(posedge clk)
   begin
      if (pready === 1'b1 && notes.size() > 0)
      begin
         note = notes.pop_front();
         if (note[33])
            check("apb answer", {pslverr, prdata}, note[32:0]);
      end
   end

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      #200000;
      n_errors++;
      complete_run();
   end

   initial
   begin
      {rst, psel, penable, pwrite, stop_mode, halt_mode} = 6'h20;
      paddr = 14'h0;
      pwdata = 32'h0;
      void'($urandom(71));
      levels = {8'hff, 8'($urandom), 32'($urandom), 8'($urandom), 8'h00};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(A_MODE, MODE_RST);
      rd(A_CLK, CLK_RST);
      xfer(14'h0000, 1'b0, 8'h00, {2'b11, 32'h0});
      xfer(A_RES, 1'b1, 8'h5a, {2'b11, 32'h0});
      $display("reset and refusal test done");
      for (k = 0; k < 8; k++)
      begin
         d = (k == 0) ? 8'h08 : {1'($urandom), 3'(k), 4'h8};
         wr(A_MODE, d);
         wait_done();
         check("channel", {30'h0, channel_sel}, 33'(k));
         check("bias", {32'h0, bias_sel}, {32'h0, d[7]});
         rd(A_RES, lev(k));
         rd(A_MODE, d ^ 8'h0c);
      end
      $display("channel sweep test done");
      wr(A_MODE, 8'h58);
      for (n = 0; sample_hold !== 1'b1 && n < 40; n++)
         @(posedge clk);
      check("start delay", 33'(n <= 17), 33'h1);
      for (n = 0; sample_hold === 1'b1 && n < 40; n++)
         @(posedge clk);
      check("sample length", 33'(n), 33'(SAMPLE_CYC));
      check("first trial", {25'h0, dac_code}, {25'h0, DAC_MSB});
      rd(A_RES, 8'h00);
      repeat (150) @(posedge clk);
      rd(A_MODE, 8'h50);
      repeat (6) @(posedge clk);
      rd(A_MODE, 8'h54);
      rd(A_RES, lev(5));
      $display("timing test done");
      wr(A_CLR, 8'h04);
      rd(A_MODE, 8'h50);
      wr(A_SET, 8'h04);
      rd(A_MODE, 8'h54);
      rd(A_SET, 8'h00);
      wr(A_SET, 8'h08);
      repeat (16) @(posedge clk);
      rd(A_MODE, 8'h50);
      wait_done();
      $display("bit set and clear test done");
      for (k = 0; k < 4; k++)
      begin
         wr(A_CLR, 8'h04);
         wr(A_CLK, (k == 0) ? 8'h08 : (k == 2) ? 8'h01 : 8'h00);
         stop_mode <= (k == 1);
         halt_mode <= (k >= 2);
         wr(A_MODE, 8'h38);
         repeat (200) @(posedge clk);
         rd(A_MODE, (k < 3) ? 8'h38 : 8'h34);
         wr(A_CLK, 8'h00);
         stop_mode <= 1'b0;
         halt_mode <= 1'b0;
         wait_done();
         rd(A_RES, lev(3));
      end
      $display("stall test done");
      @(posedge clk);
      complete_run();
   end
endmodule
`default_nettype wire

// File: test/sac_analog_model.sv
/*
   analog far side: eight input levels, a sample-and-hold and a comparator.
   assumes the levels are set by the bench and the dac settles within a clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model
   import sac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [63:0] levels,
   input  wire logic [2:0]  channel_sel,
   input  wire logic        sample_hold,
   input  wire logic [7:0]  dac_code,
   output var  logic        cmp_in
);
   logic [7:0] held_r;

   // -------------------------------------------------------------
   // hold the selected input, then compare against the trial code
   // -------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sample_hold)
         held_r <= levels[channel_sel*8 +: 8];
   end

   always_comb
   begin
      cmp_in = (held_r >= dac_code);
   end
endmodule
`default_nettype wire
